// file: sesg_pkg.sv
package sesg_pkg;
  // standard event status bit positions
  localparam int unsigned SESG_BIT_OPC  = 0;
  localparam int unsigned SESG_BIT_RQC  = 1;
  localparam int unsigned SESG_BIT_QYE  = 2;
  localparam int unsigned SESG_BIT_DDE  = 3;
  localparam int unsigned SESG_BIT_EXE  = 4;
  localparam int unsigned SESG_BIT_CME  = 5;
  localparam int unsigned SESG_BIT_URQ  = 6;
  localparam int unsigned SESG_BIT_PON  = 7;
  localparam int unsigned SESG_W        = 8;
  localparam int unsigned SESG_SUM_BIT  = 5;
  localparam logic [7:0]  SESG_MASK_RST = 8'h00;
  localparam logic [7:0]  SESG_USED     = 8'hFF;
  localparam logic [7:0]  SESG_ZERO     = 8'h00;
  // resting level of the synchronised conditions: only idle (not measuring) is high
  localparam logic [6:0]  SESG_COND_IDLE = 7'h01;
  typedef enum logic [1:0] {
    SESG_PWR_CLEAR,
    SESG_PWR_RECORD,
    SESG_PWR_RUN
  } sesg_pwr_t;
endpackage : sesg_pkg

// file: sesg_edge.sv
`timescale 1ns/10ps
// rising-edge detector for one condition; input already synchronised
module sesg_edge (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic level_i,
  output logic      rise_o
);
  logic prev;
  logic next_prev;

  always_comb begin
    next_prev = level_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end

  assign rise_o = level_i & ~prev;
endmodule : sesg_edge

// file: sesg_status.sv
`timescale 1ns/10ps
// Operation
// - enable mask is an 8-bit binary value 0..255, each bit enabling one event
// - unassigned mask bits read zero and writes to them are discarded
// - status byte bit 5 is OR of enabled latched events
// - power-on clears the enable mask to zero
// - mask survives instrument reset command and save or recall
// - event bits set on condition transitions, not levels
// - set event bits stay set until explicitly cleared
// - event latch cleared by clear-status, by its read query, and at power-on
// - power-up clears latch first, then records later events including power-on bit
// - latch read returns binary-weighted value, unassigned bits zero
// - clear-status clears all summarised event registers and the error queue
// - clear-status returns operation-complete command and query logic to idle (here opc_arm_i in the same cycle wins and leaves it armed)
// - clear-status first after terminator also clears output queue and message bit
// - armed operation-complete sets bit 0 on measuring-to-idle transition
module sesg_status
  import sesg_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // command interface from the command parser (same clock)
  input  wire logic       mask_wr_i,
  input  wire logic [7:0] mask_wdata_i,
  input  wire logic       latch_rd_i,
  input  wire logic       clear_status_i,
  input  wire logic       after_term_i,
  input  wire logic       opc_arm_i,
  input  wire logic       reset_cmd_i,
  input  wire logic       dev_clear_i,
  // event sources from the instrument (asynchronous levels)
  input  wire logic       measuring_i,
  input  wire logic       req_control_i,
  input  wire logic       query_err_i,
  input  wire logic       dev_err_i,
  input  wire logic       exec_err_i,
  input  wire logic       cmd_err_i,
  input  wire logic       user_req_i,
  // read-back, summary and clear-status pulses to neighbouring blocks
  output logic [7:0]      mask_o,
  output logic [7:0]      latch_o,
  output logic            summary_o,
  output logic            opc_armed_o,
  output logic            clr_other_events_o,
  output logic            clr_error_queue_o,
  output logic            clr_output_queue_o
);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for asynchronous condition levels
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic [6:0] raw_cond;
  logic [6:0] cond_rise;
  logic       meas_fall;

  assign raw_cond = {user_req_i, cmd_err_i, exec_err_i, dev_err_i,
                     query_err_i, req_control_i, ~measuring_i};

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync1 <= SESG_COND_IDLE;
      sync2 <= SESG_COND_IDLE;
    end else begin
      sync1 <= raw_cond;
      sync2 <= sync1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_edge
      sesg_edge u_edge (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .level_i (sync2[gi]),
        .rise_o  (cond_rise[gi])
      );
    end
  endgenerate

  // measuring-to-idle is the rise of the idle level; synchronisers rest at idle and the
  // edge seen while still clearing after reset is ignored, so no false completion
  assign meas_fall = cond_rise[0] & (pwr != SESG_PWR_CLEAR);

  ////////////////////////////////////////////////////////////////////////
  // power-up sequencing
  sesg_pwr_t pwr;
  sesg_pwr_t next_pwr;

  always_comb begin
    next_pwr = pwr;
    unique case (pwr)
      SESG_PWR_CLEAR:  next_pwr = SESG_PWR_RECORD;
      SESG_PWR_RECORD: next_pwr = SESG_PWR_RUN;
      SESG_PWR_RUN:    next_pwr = SESG_PWR_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pwr <= SESG_PWR_CLEAR;
    end else begin
      pwr <= next_pwr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enable mask, latch, operation-complete arming
  logic [7:0] mask;
  logic [7:0] next_mask;
  logic [7:0] latch;
  logic [7:0] next_latch;
  logic [7:0] set_bits;
  logic       opc_armed;
  logic       next_opc_armed;
  logic       summary;
  logic       next_summary;

  always_comb begin
    set_bits = SESG_ZERO;
    set_bits[SESG_BIT_OPC] = opc_armed & meas_fall;
    set_bits[SESG_BIT_RQC] = cond_rise[1];
    set_bits[SESG_BIT_QYE] = cond_rise[2];
    set_bits[SESG_BIT_DDE] = cond_rise[3];
    set_bits[SESG_BIT_EXE] = cond_rise[4];
    set_bits[SESG_BIT_CME] = cond_rise[5];
    set_bits[SESG_BIT_URQ] = cond_rise[6];
    set_bits[SESG_BIT_PON] = (pwr == SESG_PWR_RECORD);
  end

  always_comb begin
    // mask ignores reset_cmd_i: only power-on and mask_wr_i touch it
    next_mask = mask;
    if (mask_wr_i) begin
      next_mask = mask_wdata_i & SESG_USED;
    end
  end

  always_comb begin
    next_latch = latch;
    if (pwr == SESG_PWR_CLEAR) begin
      next_latch = SESG_ZERO;
    end else begin
      if (clear_status_i || latch_rd_i) begin
        next_latch = SESG_ZERO;
      end
      // events in the clearing cycle are kept
      next_latch = next_latch | (set_bits & SESG_USED);
    end
  end

  always_comb begin
    next_opc_armed = opc_armed;
    if (opc_arm_i) begin
      next_opc_armed = 1'b1;
    end else if (clear_status_i || reset_cmd_i || dev_clear_i || meas_fall) begin
      next_opc_armed = 1'b0;
    end
  end

  always_comb begin
    next_summary = |(next_latch & next_mask);
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mask      <= SESG_MASK_RST;
      latch     <= SESG_ZERO;
      opc_armed <= 1'b0;
      summary   <= 1'b0;
    end else begin
      mask      <= next_mask;
      latch     <= next_latch;
      opc_armed <= next_opc_armed;
      summary   <= next_summary;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clear-status side effects on neighbouring blocks
  logic clr_other;
  logic clr_err;
  logic clr_outq;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      clr_other <= 1'b0;
      clr_err   <= 1'b0;
      clr_outq  <= 1'b0;
    end else begin
      clr_other <= clear_status_i;
      clr_err   <= clear_status_i;
      clr_outq  <= clear_status_i & after_term_i;
    end
  end

  assign mask_o             = mask;
  assign latch_o            = latch;
  assign summary_o          = summary;
  assign opc_armed_o        = opc_armed;
  assign clr_other_events_o = clr_other;
  assign clr_error_queue_o  = clr_err;
  assign clr_output_queue_o = clr_outq;
endmodule : sesg_status

// file: sesg_status_assertions.sv
`timescale 1ns/10ps
module sesg_status_assertions (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       mask_wr_i,
  input wire logic [7:0] mask_wdata_i,
  input wire logic       latch_rd_i,
  input wire logic       clear_status_i,
  input wire logic       after_term_i,
  input wire logic       opc_arm_i,
  input wire logic [7:0] mask_o,
  input wire logic [7:0] latch_o,
  input wire logic       summary_o,
  input wire logic       opc_armed_o,
  input wire logic       clr_other_events_o,
  input wire logic       clr_output_queue_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  a_sum_or: assert property (summary_o == |(latch_o & mask_o))
    else $error("summary wrong");
  a_mask_wr: assert property (mask_wr_i |=> mask_o == $past(mask_wdata_i))
    else $error("mask not written");
  a_mask_hold: assert property (!mask_wr_i |=> $stable(mask_o))
    else $error("mask changed");
  a_latch_sticky: assert property (!latch_rd_i && !clear_status_i
    |=> ($past(latch_o) & ~latch_o) == 8'h00) else $error("event bit lost");
  a_clr_pulse: assert property (clear_status_i |=> clr_other_events_o)
    else $error("no event clear");
  a_oq_pulse: assert property (clear_status_i && after_term_i |=> clr_output_queue_o)
    else $error("no queue clear");
  a_opc_disarm: assert property (clear_status_i && !opc_arm_i |=> !opc_armed_o)
    else $error("still armed");
  a_pon_bit: assert property ($rose(rstn_i) |-> ##2 latch_o[7])
    else $error("no power-on bit");
endmodule : sesg_status_assertions
bind sesg_status sesg_status_assertions u_sesg_status_assertions (
  .clk_i(clk_i), .rstn_i(rstn_i), .mask_wr_i(mask_wr_i), .mask_wdata_i(mask_wdata_i),
  .latch_rd_i(latch_rd_i), .clear_status_i(clear_status_i), .after_term_i(after_term_i),
  .opc_arm_i(opc_arm_i), .mask_o(mask_o), .latch_o(latch_o), .summary_o(summary_o),
  .opc_armed_o(opc_armed_o), .clr_other_events_o(clr_other_events_o),
  .clr_output_queue_o(clr_output_queue_o));

// file: sesg_ctl.sv
`timescale 1ns/10ps
module sesg_ctl (
  input  wire logic       clk_i,
  output logic      [7:0] cmd_o,
  output logic      [7:0] dat_o
);
  initial cmd_o = 8'h00;
  initial dat_o = 8'h00;
  // strobe and data stand until the taking edge
  task send(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk_i);
    cmd_o <= c;
    dat_o <= d;
    @(posedge clk_i);
    cmd_o <= 8'h00;
    dat_o <= ~d;
  endtask : send
endmodule : sesg_ctl

// file: sesg_status_tb_top.sv
`timescale 1ns/10ps
module sesg_status_tb_top;
  logic        clk_i = 1'b0, rstn_i = 1'b0, meas = 1'b0, summary_o, armed;
  logic  [5:0] ev = 6'h00;
  logic  [2:0] clr;
  logic  [7:0] cmd, dat, mask_o, latch_o;
  int          n_mismatch = 0, n_compared = 0, cyc = 0, em, el;
  int unsigned x = 24;
  initial forever #5 clk_i = ~clk_i;
  sesg_ctl u_sesg_ctl (.clk_i(clk_i), .cmd_o(cmd), .dat_o(dat));
  sesg_status u_sesg_status (.clk_i(clk_i), .rstn_i(rstn_i), .mask_wr_i(cmd[0]),
    .mask_wdata_i(dat), .latch_rd_i(cmd[1]), .clear_status_i(cmd[2]), .after_term_i(cmd[3]),
    .opc_arm_i(cmd[4]), .reset_cmd_i(cmd[5]), .dev_clear_i(cmd[6]), .measuring_i(meas),
    .req_control_i(ev[0]), .query_err_i(ev[1]), .dev_err_i(ev[2]), .exec_err_i(ev[3]),
    .cmd_err_i(ev[4]), .user_req_i(ev[5]), .mask_o(mask_o), .latch_o(latch_o),
    .summary_o(summary_o), .opc_armed_o(armed), .clr_other_events_o(clr[2]),
    .clr_error_queue_o(clr[1]), .clr_output_queue_o(clr[0]));
  task give_verdict();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  function automatic int unsigned rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : rnd
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task look();
    chk(latch_o, 8'(el));
    chk({7'h00, summary_o}, {7'h00, |(el & em)});
  endtask : look
  task rst();
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    tick(3);
    em = 0;
    el = 8'h80;
    chk(mask_o, 8'h00);
    look();
  endtask : rst
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 2000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    rst();
    for (int i = 0; i < 4; i++) begin
      em = (i < 2) ? rnd() & 255 : {8{i[0]}};
      u_sesg_ctl.send(8'h01, 8'(em));
      #1;
      chk(mask_o, 8'(em));
      look();
    end
    for (int b = 0; b < 6; b++) begin
      @(posedge clk_i);
      ev <= ev | 6'(1 << b);
      tick(4);
      el |= 2 << b;
      look();
    end
    @(posedge clk_i);
    ev <= 6'h00;
    tick(4);
    look();
    u_sesg_ctl.send(8'h02, 8'h00);
    #1;
    el = 0;
    look();
    @(posedge clk_i);
    ev <= 6'h3F;
    tick(4);
    el = 8'h7E;
    look();
    u_sesg_ctl.send(8'h02, 8'h00);
    tick(4);
    el = 0;
    look();
    @(posedge clk_i);
    ev <= 6'h00;
    u_sesg_ctl.send(8'h10, 8'h00);
    #1;
    chk({7'h00, armed}, 8'h01);
    u_sesg_ctl.send(8'h20, 8'h00);
    #1;
    chk({7'h00, armed}, 8'h00);
    u_sesg_ctl.send(8'h10, 8'h00);
    u_sesg_ctl.send(8'h40, 8'h00);
    #1;
    chk({7'h00, armed}, 8'h00);
    chk(mask_o, 8'(em));
    @(posedge clk_i);
    meas <= 1'b1;
    u_sesg_ctl.send(8'h10, 8'h00);
    #1;
    chk({7'h00, armed}, 8'h01);
    @(posedge clk_i);
    meas <= 1'b0;
    tick(6);
    el = 1;
    look();
    chk({7'h00, armed}, 8'h00);
    u_sesg_ctl.send(8'h10, 8'h00);
    u_sesg_ctl.send(8'h0C, 8'h00);
    #1;
    el = 0;
    chk({5'h00, clr}, 8'h07);
    chk({7'h00, armed}, 8'h00);
    look();
    u_sesg_ctl.send(8'h04, 8'h00);
    #1;
    chk({5'h00, clr}, 8'h06);
    rst();
    give_verdict();
  end
endmodule : sesg_status_tb_top
